// File: watchdog_timer_control.sv
// watchdog timer with apb control register and interrupt status
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_control
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        secondary_oscillator,
	input  wire logic        internal_low_freq_oscillator,
	input  wire logic [1:0]  config_mode_field,
	input  wire logic        watchdog_clear_instruction,
	input  wire logic        sleep_active,
	output logic             device_reset,
	output logic             wake_up,
	output logic             timeout_status_n,
	output logic             powerdown_status_n,
	output logic             watchdog_reset_flag_n,
	output logic             irq
);
	//----------------------------------------------------------------------
	// state
	//----------------------------------------------------------------------
	typedef struct packed {
		logic [7:0]                       control;   // control register image
		logic [wdt_pkg::count_width-1:0] count;     // time base edge count
		logic                             base_d;    // last time base level
		logic                             sleep_d;   // last sleep level
		logic [1:0]                       irq_stat;  // sticky events
		logic [1:0]                       irq_mask;  // event enables
		logic [31:0]                      rdata;     // read data
		logic                             ready;     // access answer
		logic                             err;       // unmapped answer
		logic                             rst;       // device reset pulse
		logic                             wake;      // wake pulse
		logic                             to_n;      // timeout status
		logic                             pd_n;      // powerdown status
		logic                             watchdog_reset_flag_n_n;    // watchdog reset flag
		logic                             irq;       // interrupt line
	} state_t;

	state_t st_r;  // registered state
	state_t st_nxt; // next state

	logic secondary_oscillator_s;     // synchronised secondary oscillator
	logic lfosc_s;    // synchronised internal oscillator
	logic clr_s;      // synchronised clear instruction
	logic sleep_s;    // synchronised sleep level
	logic [1:0] mode_s0; // synchronised mode bits
	logic [wdt_pkg::count_width-1:0] terminal; // selected ratio

	//----------------------------------------------------------------------
	// input synchronisers
	//----------------------------------------------------------------------
	wdt_sync u_sync_secondary_oscillator (.pclk(pclk), .presetn(presetn), .d(secondary_oscillator), .q(secondary_oscillator_s));
	wdt_sync u_sync_lf   (.pclk(pclk), .presetn(presetn), .d(internal_low_freq_oscillator), .q(lfosc_s));
	wdt_sync u_sync_clr  (.pclk(pclk), .presetn(presetn), .d(watchdog_clear_instruction), .q(clr_s));
	wdt_sync u_sync_slp  (.pclk(pclk), .presetn(presetn), .d(sleep_active), .q(sleep_s));
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_mode
			wdt_sync u_sync_mode (.pclk(pclk), .presetn(presetn), .d(config_mode_field[gi]), .q(mode_s0[gi]));
		end
	endgenerate

	// prescale decode
	wdt_ratio u_ratio (.code(st_r.control[5:1]), .terminal(terminal));

	//----------------------------------------------------------------------
	// activity decode for a mode, sleep level and enable
	//----------------------------------------------------------------------
	function automatic logic wdt_active(input logic [1:0] mode, input logic asleep, input logic software_enable);
		unique case (mode)
			wdt_pkg::mode_always:   wdt_active = 1'b1;
			wdt_pkg::mode_awake:    wdt_active = !asleep;
			wdt_pkg::mode_software: wdt_active = software_enable;
			wdt_pkg::mode_off:      wdt_active = 1'b0;
		endcase
	endfunction

	//----------------------------------------------------------------------
	// next state
	//----------------------------------------------------------------------
	always_comb
	begin
		logic base;
		logic tick;
		logic active;
		logic wr_acc;
		logic rd_acc;
		logic ctrl_wr;
		logic clear;
		logic timeout;
		logic [1:0] events;
		base    = 1'b0;
		tick    = 1'b0;
		active  = 1'b0;
		wr_acc  = 1'b0;
		rd_acc  = 1'b0;
		ctrl_wr = 1'b0;
		clear   = 1'b0;
		timeout = 1'b0;
		events  = 2'h0;
		st_nxt  = st_r;

		// bus access phase, answered in one cycle
		wr_acc = psel && penable && pwrite && !st_r.ready;
		rd_acc = psel && penable && !pwrite && !st_r.ready;
		ctrl_wr = wr_acc && (paddr == wdt_pkg::watchdog_control_addr) && pstrb[0];

		// time base choice and edge detect
		base = st_r.control[wdt_pkg::clock_select_bit] ? secondary_oscillator_s : lfosc_s;
		tick = base && !st_r.base_d;
		st_nxt.base_d = base;
		st_nxt.sleep_d = sleep_s;

		// sleep mode level handling
		active = wdt_active(mode_s0, sleep_s, st_r.control[wdt_pkg::software_enable_bit]);

		// clearing events
		clear = clr_s || (sleep_s != st_r.sleep_d) || ctrl_wr;

		// counting
		timeout = active && tick && (st_r.count + 1'b1 >= terminal);
		if (clear || !active)
			st_nxt.count = '0;
		else if (timeout)
			st_nxt.count = '0;
		else if (tick)
			st_nxt.count = st_r.count + 1'b1;

		// time-out effects
		st_nxt.rst  = timeout && !sleep_s && !clear;
		st_nxt.wake = timeout && sleep_s && !clear;
		if (timeout && !clear)
		begin
			st_nxt.watchdog_reset_flag_n_n = 1'b0;
			if (sleep_s)
			begin
				st_nxt.to_n = 1'b0;
				st_nxt.pd_n = 1'b0;
			end
		end

		// register writes
		if (ctrl_wr)
		begin
			st_nxt.control = pwdata[7:0] & ~(8'h01 << wdt_pkg::unused_bit);
		end
		if (wr_acc && paddr == wdt_pkg::irq_mask_addr && pstrb[0])
			st_nxt.irq_mask = pwdata[1:0];

		// sticky events, set wins over the write-one clear
		events[wdt_pkg::irq_timeout_bit] = st_nxt.rst;
		events[wdt_pkg::irq_wake_bit]    = st_nxt.wake;
		if (wr_acc && paddr == wdt_pkg::irq_status_addr && pstrb[0])
			st_nxt.irq_stat = (st_r.irq_stat & ~pwdata[1:0]) | events;
		else
			st_nxt.irq_stat = st_r.irq_stat | events;
		st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);

		// read data and answer
		st_nxt.ready = (psel && penable && !st_r.ready);
		st_nxt.err   = 1'b0;
		st_nxt.rdata = 32'h0;
		if (psel && penable && !st_r.ready)
		begin
			unique case (paddr)
				wdt_pkg::watchdog_control_addr: st_nxt.rdata = {24'h0, st_r.control};
				wdt_pkg::irq_status_addr:       st_nxt.rdata = {30'h0, st_r.irq_stat};
				wdt_pkg::irq_mask_addr:         st_nxt.rdata = {30'h0, st_r.irq_mask};
				wdt_pkg::state_addr:            st_nxt.rdata = {21'h0, st_r.watchdog_reset_flag_n_n, st_r.pd_n, st_r.to_n, active, sleep_s, mode_s0, 4'h0};
				default:                        st_nxt.err   = 1'b1;
			endcase
			if (!rd_acc)
				st_nxt.rdata = 32'h0;
		end
	end

	//----------------------------------------------------------------------
	// state register
	//----------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_r         <= '0;
			st_r.control <= wdt_pkg::control_reset;
			st_r.to_n    <= 1'b1;
			st_r.pd_n    <= 1'b1;
			st_r.watchdog_reset_flag_n_n  <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	// outputs straight from the state register
	assign prdata               = st_r.rdata;
	assign pready               = st_r.ready;
	assign pslverr              = st_r.err;
	assign device_reset         = st_r.rst;
	assign wake_up              = st_r.wake;
	assign timeout_status_n     = st_r.to_n;
	assign powerdown_status_n   = st_r.pd_n;
	assign watchdog_reset_flag_n = st_r.watchdog_reset_flag_n_n;
	assign irq                  = st_r.irq;
endmodule
`default_nettype wire

// File: watchdog_timer_control_asserts.sv
// port checker for the watchdog timer block
`timescale 1ns/1ps
`default_nettype none
module wdt_port_checker
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [1:0]  config_mode_field,
	input wire logic        sleep_active,
	input wire logic        device_reset,
	input wire logic        wake_up,
	input wire logic        timeout_status_n,
	input wire logic        powerdown_status_n,
	input wire logic        watchdog_reset_flag_n
);
	//--------------------------------------------------------------
	// properties on the bus and the event outputs
	//--------------------------------------------------------------
	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_follows_access:
		assert property (psel && penable && !pready |=> pready) else $error("pready late");
	a_ready_one_cycle:
		assert property (pready |=> !pready) else $error("pready too long");
	a_error_reads_zero:
		assert property (pready && pslverr |-> prdata == 32'h0) else $error("error data not zero");
	a_reset_pulse_single:
		assert property (device_reset |=> !device_reset) else $error("reset pulse too long");
	a_asleep_no_reset:
		assert property (sleep_active [*4] |-> !device_reset) else $error("reset while asleep");
	a_awake_no_wake:
		assert property (!sleep_active [*4] |-> !wake_up) else $error("wake while awake");
	a_wake_sets_flags:
		assert property (wake_up |-> ##[0:1] (!timeout_status_n && !powerdown_status_n)) else $error("flags kept");
	a_event_marks_flag:
		assert property (device_reset || wake_up |-> ##[0:1] !watchdog_reset_flag_n) else $error("flag kept");
	a_flag_stays_low:
		assert property (!watchdog_reset_flag_n |=> !watchdog_reset_flag_n) else $error("flag lost");
	a_status_pair_match:
		assert property (timeout_status_n == powerdown_status_n) else $error("status pair split");
	a_off_mode_quiet:
		assert property (config_mode_field == 2'h0 [*5] |-> !device_reset && !wake_up) else $error("event when off");
	// main scenarios reached
	c_reset: cover property (device_reset);
	c_wake: cover property (wake_up);
	c_error: cover property (pready && pslverr);
endmodule
bind watchdog_timer_control wdt_port_checker chk_u (.*);
`default_nettype wire

// File: watchdog_timer_control_bench.sv
// self-checking bench for the watchdog timer block
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_control_bench;
	//--------------------------------------------------------------
	// stimulus and observed signals
	//--------------------------------------------------------------
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, irq;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0]  pstrb = 4'hf;
	logic        secondary_oscillator = 0, internal_low_freq_oscillator = 0;
	logic        watchdog_clear_instruction = 0, sleep_active = 0;
	logic [1:0]  config_mode_field = 2'h3;
	logic        device_reset, wake_up, timeout_status_n, powerdown_status_n, watchdog_reset_flag_n;
	int          fails = 0, check_count = 0, rst_cnt = 0, wake_cnt = 0;
	always #2.5 pclk = ~pclk;
	watchdog_timer_control dut_u (.*);
	// count one-cycle event pulses
	always @(posedge pclk)
	begin
		if (device_reset === 1'b1) rst_cnt++;
		if (wake_up === 1'b1) wake_cnt++;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// n rising edges on one time base, then settle
	task automatic pulse(input logic sel, input int n);
		repeat (n)
		begin
			@(posedge pclk);
			if (sel) secondary_oscillator <= 1'b1;
			else internal_low_freq_oscillator <= 1'b1;
			repeat (3) @(posedge pclk);
			secondary_oscillator <= 1'b0;
			internal_low_freq_oscillator <= 1'b0;
			repeat (2) @(posedge pclk);
		end
		repeat (8) @(posedge pclk);
	endtask
	// set the mode, write the control register, zero the event counts
	task automatic prep(input logic [1:0] m, input logic [7:0] c);
		config_mode_field <= m;
		repeat (4) @(posedge pclk);
		apb(1'b1, wdt_pkg::watchdog_control_addr, {24'h0, c});
		rst_cnt = 0;
		wake_cnt = 0;
	endtask
	//--------------------------------------------------------------
	// scenarios
	//--------------------------------------------------------------
	task automatic t_reset();
		apb(1'b0, wdt_pkg::watchdog_control_addr, 32'h0);
		check(rd, 32'h16);
		check({29'h0, timeout_status_n, powerdown_status_n, watchdog_reset_flag_n}, 32'h7);
		apb(1'b1, wdt_pkg::watchdog_control_addr, 32'hff);
		apb(1'b0, wdt_pkg::watchdog_control_addr, 32'h0);
		check(rd, 32'hbf);
		apb(1'b0, 12'h000, 32'h0);
		check({31'h0, err}, 32'h1);
		check(rd, 32'h0);
	endtask
	// exact terminal count, then the interrupt path
	task automatic t_count();
		prep(2'h3, 8'h00);
		pulse(1'b0, 31);
		check(rst_cnt, 0);
		pulse(1'b0, 1);
		check(rst_cnt, 1);
		check({29'h0, timeout_status_n, powerdown_status_n, watchdog_reset_flag_n}, 32'h6);
		apb(1'b0, wdt_pkg::irq_status_addr, 32'h0);
		check(rd, 32'h1);
		check({31'h0, irq}, 32'h0);
		apb(1'b1, wdt_pkg::irq_mask_addr, 32'h1);
		repeat (2) @(posedge pclk);
		check({31'h0, irq}, 32'h1);
		apb(1'b1, wdt_pkg::irq_status_addr, 32'h1);
		repeat (2) @(posedge pclk);
		check({31'h0, irq}, 32'h0);
	endtask
	// clear input restarts the count
	task automatic t_clear();
		prep(2'h3, 8'h00);
		pulse(1'b0, 20);
		watchdog_clear_instruction <= 1'b1;
		repeat (4) @(posedge pclk);
		watchdog_clear_instruction <= 1'b0;
		pulse(1'b0, 20);
		check(rst_cnt, 0);
		pulse(1'b0, 12);
		check(rst_cnt, 1);
	endtask
	// reserved code, clock select, software enable and off mode
	task automatic t_modes();
		prep(2'h3, 8'h26);
		pulse(1'b0, 32);
		check(rst_cnt, 1);
		prep(2'h3, 8'h80);
		pulse(1'b0, 40);
		pulse(1'b1, 32);
		check(rst_cnt, 1);
		prep(2'h1, 8'h00);
		pulse(1'b0, 40);
		check(rst_cnt, 0);
		prep(2'h1, 8'h01);
		pulse(1'b0, 32);
		check(rst_cnt, 1);
		prep(2'h0, 8'h01);
		pulse(1'b0, 40);
		check(rst_cnt, 0);
	endtask
	// sleep behaviour in awake-only and always modes
	task automatic t_sleep();
		prep(2'h2, 8'h00);
		sleep_active <= 1'b1;
		pulse(1'b0, 40);
		check(rst_cnt + wake_cnt, 0);
		sleep_active <= 1'b0;
		prep(2'h3, 8'h00);
		pulse(1'b0, 20);
		sleep_active <= 1'b1;
		pulse(1'b0, 20);
		check(wake_cnt, 0);
		pulse(1'b0, 12);
		check(wake_cnt, 1);
		check(rst_cnt, 0);
		check({29'h0, timeout_status_n, powerdown_status_n, watchdog_reset_flag_n}, 32'h0);
		// state word: flags low, active, asleep, mode always
		apb(1'b0, wdt_pkg::state_addr, 32'h0);
		check(rd, 32'hf0);
		sleep_active <= 1'b0;
	endtask
	task automatic results();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		t_reset();
		t_count();
		t_clear();
		t_modes();
		t_sleep();
		results();
	end
	// hang guard
	initial
	begin
		#200us;
		fails++;
		results();
	end
endmodule
`default_nettype wire

// File: wdt_pkg.sv
// package of constants for the watchdog timer block
//----------------------------------------------------------------------
// What this block does
// - clear count on reset, clear, sleep edges, write
// - in sleep, count only if mode allows
// - time-out asleep wakes, never resets
// - sleep time-out zeroes timeout and powerdown status
// - any time-out clears watchdog reset flag
// - bit 7 selects secondary or internal oscillator
// - prescale field bits 5:1, ratio 32 doubling
// - reserved prescale codes use ratio 1:32
// - prescale resets to code 01011, 1:65536
// - software enable obeyed only in mode 01
// - internal oscillator intervals 1 ms to 256 s
// - mode field selects always, awake, software, off
// - awake time-out without clear resets device
//----------------------------------------------------------------------
package wdt_pkg;
	// register byte addresses
	localparam logic [11:0] watchdog_control_addr = 12'h18c;
	localparam logic [11:0] irq_status_addr       = 12'h190;
	localparam logic [11:0] irq_mask_addr         = 12'h194;
	localparam logic [11:0] state_addr            = 12'h198;
	// field positions inside the control register
	localparam int clock_select_bit  = 7;
	localparam int unused_bit        = 6;
	localparam int prescale_lsb      = 1;
	localparam int software_enable_bit = 0;
	// reset values and prescale code limits
	localparam logic [4:0] prescale_reset  = 5'h0b;
	localparam logic [4:0] prescale_max    = 5'h12;
	localparam logic [4:0] prescale_min    = 5'h00;
	localparam logic [7:0] control_reset   = 8'h16;
	// base ratio exponent: code 0 gives 2**5
	localparam int ratio_base_log2 = 5;
	// nominal interval figures with the internal oscillator
	localparam int min_interval_ms = 1;
	localparam int max_interval_s  = 256;
	// operating modes of the configuration field
	localparam logic [1:0] mode_off      = 2'h0;
	localparam logic [1:0] mode_software = 2'h1;
	localparam logic [1:0] mode_awake    = 2'h2;
	localparam logic [1:0] mode_always   = 2'h3;
	// interrupt status bit positions
	localparam int irq_timeout_bit = 0;
	localparam int irq_wake_bit    = 1;
	// count width: enough for 2**23
	localparam int count_width = 24;
endpackage

// File: wdt_ratio.sv
// decoder from prescale code to terminal count
`timescale 1ns/1ps
`default_nettype none
module wdt_ratio
(
	input  wire logic [4:0]                       code,
	output logic      [wdt_pkg::count_width-1:0] terminal
);
	//----------------------------------------------------------------------
	// ratio 2**(code+5), reserved codes fall back to the minimum
	//----------------------------------------------------------------------
	always_comb
	begin
		if (code > wdt_pkg::prescale_max)
			terminal = wdt_pkg::count_width'(1) << wdt_pkg::ratio_base_log2;
		else
			terminal = wdt_pkg::count_width'(1) << (5'(wdt_pkg::ratio_base_log2) + code);
	end
endmodule
`default_nettype wire

// File: wdt_sync.sv
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module wdt_sync
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic d,
	output logic      q
);
	logic meta_r; // first stage, read only by the second
	//----------------------------------------------------------------------
	// two stage capture
	//----------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_r <= 1'b0;
			q      <= 1'b0;
		end
		else
		begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule
`default_nettype wire
